// >>> dv/sis_card_model.sv
`timescale 1ns/100ps
module sis_card_model (
    // Card state set by the bench
    input wire logic [1:0] present_in,
    input wire logic is_io_in,
    input wire logic ready_in,
    input wire logic wlock_in,
    input wire logic [1:0] pair_in,
    // Socket pins
    output logic ready_pin_out,
    output logic wlock_pin_out,
    output logic [1:0] insert_n_out,
    output logic [1:0] batt_pins_out,
    output logic [1:0] io_pins_out
);
    logic seated;
    // One detect contact per bit; card drives only when fully seated
    assign seated = &present_in;
    // Detect pins pulled up, unused lines show inverted value
    assign insert_n_out = ~present_in;
    assign ready_pin_out = seated ? ready_in : !ready_in;
    assign wlock_pin_out = seated ? wlock_in : !wlock_in;
    assign batt_pins_out = (seated && !is_io_in) ? pair_in : ~pair_in;
    assign io_pins_out = (seated && is_io_in) ? pair_in : ~pair_in;
endmodule : sis_card_model

// >>> dv/sis_regs_checker.sv
`timescale 1ns/100ps
module sis_regs_checker (
    // Clock, resets and register port
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic host_bus_reset_pin_n_in,
    input wire logic [11:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic reg_rvalid_out,
    // Control and mode
    input wire logic id_write_lock_in,
    input wire logic socket_power_on_in,
    input wire logic legacy_emulation_out,
    input wire logic [3:0] compat_revision_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    sequence rd_id;
        reg_rvalid_out && $past(reg_addr_in) == sis_pkg::ID_OFFSET;
    endsequence
    sequence rd_st;
        reg_rvalid_out && $past(reg_addr_in) == sis_pkg::STATUS_OFFSET;
    endsequence
    sequence bus_idle;
        host_bus_reset_pin_n_in [*3];
    endsequence
    rvalid_cause_a: assert property (
        reg_rvalid_out |-> $past(reg_rd_in)) else $error("stray rvalid");
    read_answer_a: assert property (
        bus_idle ##0 (reg_rd_in && $past(rstn_in, 3)) |=> reg_rvalid_out)
        else $error("read not answered");
    kind_fixed_a: assert property (
        rd_id |-> reg_rdata_out[7:6] == sis_pkg::INTERFACE_KIND)
        else $error("interface kind wrong");
    status_bit7_a: assert property (
        rd_st |-> !reg_rdata_out[7]) else $error("status bit 7 set");
    power_bit_a: assert property (
        rd_st ##0 $past(socket_power_on_in, 2) == $past(socket_power_on_in)
        |-> reg_rdata_out[6] == $past(socket_power_on_in))
        else $error("power bit wrong");
    legacy_track_a: assert property (
        legacy_emulation_out ==
        (compat_revision_out == sis_pkg::REV_LEGACY_MODE))
        else $error("legacy mode wrong");
    id_lock_a: assert property (
        $past(reg_wr_in && id_write_lock_in) |-> $stable(compat_revision_out))
        else $error("locked id changed");
    rev_write_a: assert property (
        $past(reg_wr_in && !id_write_lock_in &&
        reg_addr_in == sis_pkg::ID_OFFSET)
        |-> compat_revision_out == $past(reg_wdata_in[3:0]))
        else $error("revision not written");
endmodule : sis_regs_checker

bind sis_socket_regs sis_regs_checker sis_regs_checker_inst (.mclk_in,
    .rstn_in, .host_bus_reset_pin_n_in, .reg_addr_in, .reg_wr_in,
    .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out,
    .id_write_lock_in, .socket_power_on_in, .legacy_emulation_out,
    .compat_revision_out);

// >>> dv/testbench.sv
`timescale 1ns/100ps
module testbench;
    logic mclk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic host_bus_reset_pin_n_in = 1'b0;
    logic [11:0] reg_addr_in = 12'h000;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [7:0] reg_wdata_in = 8'h00;
    logic id_write_lock_in = 1'b0;
    logic socket_power_on_in = 1'b0;
    logic card_is_io_in = 1'b0;
    logic [1:0] present = 2'h3;
    logic ready = 1'b0;
    logic wlock = 1'b0;
    logic [1:0] pair = 2'h0;
    logic card_ready_pin_in, card_write_lock_pin_in;
    logic [1:0] batt, iop, ins_n;
    logic [7:0] reg_rdata_out, d;
    logic reg_rvalid_out, legacy_emulation_out;
    logic [3:0] compat_revision_out;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    sis_socket_regs sis_socket_regs_inst (.mclk_in, .rstn_in,
        .host_bus_reset_pin_n_in, .reg_addr_in, .reg_wr_in, .reg_rd_in,
        .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .id_write_lock_in,
        .socket_power_on_in, .card_is_io_in, .card_ready_pin_in,
        .card_write_lock_pin_in, .insert_pin_one_n_in(ins_n[0]),
        .insert_pin_two_n_in(ins_n[1]), .battery_pin_one_in(batt[0]),
        .battery_pin_two_in(batt[1]), .audio_out_pin_in(iop[1]),
        .status_change_pin_in(iop[0]), .legacy_emulation_out,
        .compat_revision_out);
    sis_card_model sis_card_model_inst (.present_in(present),
        .is_io_in(card_is_io_in), .ready_in(ready), .wlock_in(wlock),
        .pair_in(pair), .ready_pin_out(card_ready_pin_in),
        .wlock_pin_out(card_write_lock_pin_in), .insert_n_out(ins_n),
        .batt_pins_out(batt), .io_pins_out(iop));
    initial begin
        forever #20 mclk_in = ~mclk_in;
    end
    task automatic conclude;
        if (miscompares == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude
    always @(posedge mclk_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr_reg(input logic [11:0] a, input logic [7:0] v);
        @(posedge mclk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= v;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [11:0] a);
        @(posedge mclk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
        // Pulse still stands here, before this edge's updates land
        @(posedge mclk_in);
        d = (reg_rvalid_out === 1'b1) ? reg_rdata_out : 8'hxx;
    endtask : rd_reg
    function automatic logic [7:0] exp_st();
        return {1'b0, socket_power_on_in, ready, wlock, present, pair};
    endfunction : exp_st
    task automatic t_defaults;
        rd_reg(sis_pkg::ID_OFFSET);
        cmp(d, 8'h83);
        rd_reg(sis_pkg::STATUS_OFFSET);
        cmp(d, exp_st());
        rd_reg(12'h802);
        cmp(d, 8'h00);
    endtask : t_defaults
    task automatic t_id_write;
        wr_reg(sis_pkg::ID_OFFSET, 8'h72);
        rd_reg(sis_pkg::ID_OFFSET);
        cmp(d, 8'hb2);
        cmp({7'h0, legacy_emulation_out}, 8'h01);
        wr_reg(sis_pkg::ID_OFFSET, 8'h05);
        rd_reg(sis_pkg::ID_OFFSET);
        cmp(d, 8'h85);
        cmp({3'h0, legacy_emulation_out, compat_revision_out}, 8'h05);
    endtask : t_id_write
    task automatic t_lock_and_ro;
        id_write_lock_in <= 1'b1;
        wr_reg(sis_pkg::ID_OFFSET, 8'h3a);
        rd_reg(sis_pkg::ID_OFFSET);
        cmp(d, 8'h85);
        id_write_lock_in <= 1'b0;
        wr_reg(sis_pkg::STATUS_OFFSET, 8'hff);
        rd_reg(sis_pkg::STATUS_OFFSET);
        cmp(d, exp_st());
    endtask : t_lock_and_ro
    task automatic t_bus_reset;
        host_bus_reset_pin_n_in <= 1'b0;
        repeat (4) @(posedge mclk_in);
        host_bus_reset_pin_n_in <= 1'b1;
        repeat (4) @(posedge mclk_in);
        rd_reg(sis_pkg::ID_OFFSET);
        cmp(d, 8'h85);
    endtask : t_bus_reset
    task automatic t_global_reset;
        wr_reg(sis_pkg::ID_OFFSET, 8'h12);
        rstn_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        rstn_in <= 1'b1;
        repeat (4) @(posedge mclk_in);
        rd_reg(sis_pkg::ID_OFFSET);
        cmp(d, 8'h83);
        cmp({7'h0, legacy_emulation_out}, 8'h00);
    endtask : t_global_reset
    task automatic t_pins;
        for (int i = 0; i < 64; i++) begin
            {socket_power_on_in, card_is_io_in, ready, wlock, pair} <= 6'(i);
            repeat (4) @(posedge mclk_in);
            rd_reg(sis_pkg::STATUS_OFFSET);
            cmp(d, exp_st());
        end
        for (int k = 2; k >= 0; k--) begin
            present <= 2'(k);
            repeat (4) @(posedge mclk_in);
            rd_reg(sis_pkg::STATUS_OFFSET);
            cmp(d & 8'h0c, {4'h0, 2'(k), 2'h0});
        end
    endtask : t_pins
    initial begin
        repeat (12) @(posedge mclk_in);
        rstn_in <= 1'b1;
        host_bus_reset_pin_n_in <= 1'b1;
        repeat (4) @(posedge mclk_in);
        t_defaults();
        t_id_write();
        t_lock_and_ro();
        t_bus_reset();
        t_global_reset();
        t_pins();
        conclude();
    end
endmodule : testbench

// >>> include/sis_pkg.sv
package sis_pkg;

    // Register port geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;

    // Byte offsets on the host register port
    localparam logic [11:0] ID_OFFSET = 12'h800;
    localparam logic [11:0] STATUS_OFFSET = 12'h801;

    // Identification register fields
    localparam int KIND_MSB = 7;
    localparam int KIND_LSB = 6;
    localparam int SPARE_MSB = 5;
    localparam int SPARE_LSB = 4;
    localparam int REV_MSB = 3;
    localparam int REV_LSB = 0;
    localparam logic [1:0] INTERFACE_KIND = 2'h2;
    localparam logic [1:0] SPARE_RESET = 2'h0;
    localparam logic [3:0] REV_LEGACY_MODE = 4'h2;

    // Interface status register fields
    localparam int ST_RSVD_BIT = 7;
    localparam int ST_POWER_BIT = 6;
    localparam int ST_READY_BIT = 5;
    localparam int ST_WLOCK_BIT = 4;
    localparam int ST_INS2_BIT = 3;
    localparam int ST_INS1_BIT = 2;
    localparam int ST_PAIR_MSB = 1;
    localparam int ST_PAIR_LSB = 0;

    // Synchronised socket pin vector layout
    localparam int PIN_READY = 0;
    localparam int PIN_WLOCK = 1;
    localparam int PIN_INS1_N = 2;
    localparam int PIN_INS2_N = 3;
    localparam int PIN_BATT1 = 4;
    localparam int PIN_BATT2 = 5;
    localparam int PIN_AUDIO = 6;
    localparam int PIN_STATUS_CHANGE_PIN = 7;
    localparam int PIN_BUS_RST_N = 8;
    localparam int PIN_COUNT = 9;

    // Synchroniser depth
    localparam int SYNC_STAGES = 2;

    localparam logic [7:0] RDATA_RESET = 8'h00;

endpackage : sis_pkg

// >>> logic/sis_socket_regs.sv
`timescale 1ns/100ps
// Summary of operation
// (R1) Id bits 7-6 are hardwired read-only 10b, I/O and memory cards.
// (R2) Id bits 5-4 are plain read/write spare bits for emulation.
// (R3) Id bits 3-0 hold a writable revision code with reset default.
// (R4) Writing 0010b into the revision code enters older-controller emulation.
// (R5) Id fields reset only by global reset, never by bus reset.
// (R6) While the id write lock is set, id register ignores writes.
// (R7) Status register is read-only; bit 7 reads zero; writes ignored.
// (R8) Status bit 6 shows programmed socket power, zero after reset.
// (R9) Status bit 5 follows the card ready pin.
// (R10) Status bit 4 follows the card write-lock pin non-inverted.
// (R11) Status bit 3 is second insertion sense pin inverted.
// (R12) Status bit 2 is first insertion sense pin inverted.
// (R13) Memory card: bits 1-0 are battery pins two and one.
// (R14) I/O card: bit 1 is audio pin, bit 0 status-change pin.
// (R15) After reset status reads zero in bits 7-6, pins below.
// (R16) Socket pins are synchronised before reaching read data.

module sis_socket_regs #(
    parameter logic [3:0] REV_DEFAULT = 4'h3, // Arbitrary value
    parameter int SYNC_DEPTH = sis_pkg::SYNC_STAGES
) (
    // Clock and global reset
    input wire logic mclk_in,
    input wire logic rstn_in,
    // Host bus reset pin, asynchronous, active low
    input wire logic host_bus_reset_pin_n_in,
    // Host register port
    input wire logic [sis_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [sis_pkg::DATA_W-1:0] reg_wdata_in,
    output logic [sis_pkg::DATA_W-1:0] reg_rdata_out,
    output logic reg_rvalid_out,
    // Same-clock control from neighbouring registers
    input wire logic id_write_lock_in,
    input wire logic socket_power_on_in,
    input wire logic card_is_io_in,
    // Socket pins
    input wire logic card_ready_pin_in,
    input wire logic card_write_lock_pin_in,
    input wire logic insert_pin_one_n_in,
    input wire logic insert_pin_two_n_in,
    input wire logic battery_pin_one_in,
    input wire logic battery_pin_two_in,
    input wire logic audio_out_pin_in,
    input wire logic status_change_pin_in,
    // Mode outputs
    output logic legacy_emulation_out,
    output logic [3:0] compat_revision_out
);

    initial begin
        if (SYNC_DEPTH < 2) begin
            $error("sis_socket_regs: SYNC_DEPTH must be >= 2");
        end
        if (REV_DEFAULT == sis_pkg::REV_LEGACY_MODE) begin
            $error("sis_socket_regs: REV_DEFAULT must not select emulation");
        end
    end

    typedef struct packed {
        logic [1:0] id_spare;
        logic [3:0] compat_revision;
        logic legacy_mode;
        logic socket_power_on;
        logic [7:0] rdata;
        logic rvalid;
    } sis_state_type;

    sis_state_type state_ff;
    sis_state_type nxt_state;

    logic [sis_pkg::PIN_COUNT-1:0] pins_raw;
    logic [sis_pkg::PIN_COUNT-1:0] pins_sync;
    logic [7:0] id_byte;
    logic [7:0] status_byte;
    logic id_write_ok;
    logic bus_reset_active;

    // Every socket pin crosses two flops first [R16]
    assign pins_raw[sis_pkg::PIN_READY] = card_ready_pin_in;
    assign pins_raw[sis_pkg::PIN_WLOCK] = card_write_lock_pin_in;
    assign pins_raw[sis_pkg::PIN_INS1_N] = insert_pin_one_n_in;
    assign pins_raw[sis_pkg::PIN_INS2_N] = insert_pin_two_n_in;
    assign pins_raw[sis_pkg::PIN_BATT1] = battery_pin_one_in;
    assign pins_raw[sis_pkg::PIN_BATT2] = battery_pin_two_in;
    assign pins_raw[sis_pkg::PIN_AUDIO] = audio_out_pin_in;
    assign pins_raw[sis_pkg::PIN_STATUS_CHANGE_PIN] = status_change_pin_in;
    assign pins_raw[sis_pkg::PIN_BUS_RST_N] = host_bus_reset_pin_n_in;

    sis_sync_bank #(
        .WIDTH(sis_pkg::PIN_COUNT),
        .STAGES(SYNC_DEPTH)
    ) u_pin_sync (
        .clk_in(mclk_in),
        .rstn_in(rstn_in),
        .d_in(pins_raw),
        .q_out(pins_sync)
    ); // [R16]

    assign bus_reset_active = ~pins_sync[sis_pkg::PIN_BUS_RST_N];

    always_comb begin
        id_byte = '0;
        id_byte[sis_pkg::KIND_MSB:sis_pkg::KIND_LSB] =
            sis_pkg::INTERFACE_KIND; // [R1]
        id_byte[sis_pkg::SPARE_MSB:sis_pkg::SPARE_LSB] =
            state_ff.id_spare; // [R2]
        id_byte[sis_pkg::REV_MSB:sis_pkg::REV_LSB] =
            state_ff.compat_revision; // [R3]
    end

    always_comb begin
        status_byte = '0;
        status_byte[sis_pkg::ST_RSVD_BIT] = 1'b0; // [R7]
        status_byte[sis_pkg::ST_POWER_BIT] =
            state_ff.socket_power_on; // [R8] [R15]
        status_byte[sis_pkg::ST_READY_BIT] =
            pins_sync[sis_pkg::PIN_READY]; // [R9]
        status_byte[sis_pkg::ST_WLOCK_BIT] =
            pins_sync[sis_pkg::PIN_WLOCK]; // [R10]
        status_byte[sis_pkg::ST_INS2_BIT] =
            ~pins_sync[sis_pkg::PIN_INS2_N]; // [R11]
        status_byte[sis_pkg::ST_INS1_BIT] =
            ~pins_sync[sis_pkg::PIN_INS1_N]; // [R12]
        if (card_is_io_in) begin
            status_byte[sis_pkg::ST_PAIR_MSB] =
                pins_sync[sis_pkg::PIN_AUDIO]; // [R14]
            status_byte[sis_pkg::ST_PAIR_LSB] =
                pins_sync[sis_pkg::PIN_STATUS_CHANGE_PIN]; // [R14]
        end else begin
            status_byte[sis_pkg::ST_PAIR_MSB] =
                pins_sync[sis_pkg::PIN_BATT2]; // [R13]
            status_byte[sis_pkg::ST_PAIR_LSB] =
                pins_sync[sis_pkg::PIN_BATT1]; // [R13]
        end
    end

    assign id_write_ok = reg_wr_in && !id_write_lock_in &&
        (reg_addr_in == sis_pkg::ID_OFFSET); // [R6]

    always_comb begin
        nxt_state = state_ff;
        nxt_state.rvalid = 1'b0;
        nxt_state.socket_power_on = socket_power_on_in; // [R8]
        // Id fields ignore the bus reset; only rstn_in clears them
        if (id_write_ok) begin
            nxt_state.id_spare =
                reg_wdata_in[sis_pkg::SPARE_MSB:sis_pkg::SPARE_LSB]; // [R2]
            nxt_state.compat_revision =
                reg_wdata_in[sis_pkg::REV_MSB:sis_pkg::REV_LSB]; // [R3] [R5]
        end
        nxt_state.legacy_mode = (nxt_state.compat_revision ==
            sis_pkg::REV_LEGACY_MODE); // [R4]
        // Writes to the status offset fall through untouched
        if (reg_rd_in) begin
            nxt_state.rvalid = 1'b1;
            case (reg_addr_in)
                sis_pkg::ID_OFFSET: begin
                    nxt_state.rdata = id_byte;
                end
                sis_pkg::STATUS_OFFSET: begin
                    nxt_state.rdata = status_byte; // [R7]
                end
                default: begin
                    nxt_state.rdata = sis_pkg::RDATA_RESET;
                end
            endcase
        end
        // Bus reset only quiets the read port
        if (bus_reset_active) begin
            nxt_state.rdata = sis_pkg::RDATA_RESET;
            nxt_state.rvalid = 1'b0;
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_ff.id_spare <= sis_pkg::SPARE_RESET; // [R5]
            state_ff.compat_revision <= REV_DEFAULT; // [R3] [R5]
            state_ff.legacy_mode <= 1'b0;
            state_ff.socket_power_on <= 1'b0; // [R15]
            state_ff.rdata <= sis_pkg::RDATA_RESET;
            state_ff.rvalid <= 1'b0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign reg_rdata_out = state_ff.rdata;
    assign reg_rvalid_out = state_ff.rvalid;
    assign legacy_emulation_out = state_ff.legacy_mode;
    assign compat_revision_out = state_ff.compat_revision;

endmodule : sis_socket_regs

// >>> logic/sis_sync_bank.sv
`timescale 1ns/100ps

module sis_sync_bank #(
    parameter int WIDTH = 1,
    parameter int STAGES = 2
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Asynchronous levels in, synchronised levels out
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);

    initial begin
        if (STAGES < 2 || WIDTH < 1) begin
            $error("sis_sync_bank: STAGES must be >= 2, WIDTH >= 1");
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            logic [STAGES-1:0] chain_ff;
            // First stage is read only by the next stage
            always_ff @(posedge clk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    chain_ff <= '0;
                end else begin
                    chain_ff <= {chain_ff[STAGES-2:0], d_in[gi]};
                end
            end
            assign q_out[gi] = chain_ff[STAGES-1];
        end
    endgenerate

endmodule : sis_sync_bank
